// File: logic/cit_pkg.sv
// constants, field layouts and carrier types for the cable routing and time snapshot block
// assumes a single 20 MHz clock and a plain register port with one-cycle read latency
package cit_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NS_W = 30;
	localparam int SEL_W = 6;
	localparam int LINES = 12;
	// register byte offsets
	localparam logic [11:0] OFF_ROUTE_A = 12'h080;
	localparam logic [11:0] OFF_ROUTE_B = 12'h084;
	localparam logic [11:0] OFF_ROUTE_HI = 12'h088;
	localparam logic [11:0] OFF_PPS_SNAP = 12'h200;
	localparam logic [11:0] OFF_CABLE_SNAP = 12'h210;
	localparam logic [11:0] OFF_MASTER_SEC = 12'h220;
	localparam logic [11:0] OFF_CONTROL = 12'h224;
	localparam logic [11:0] OFF_STATUS = 12'h230;
	localparam logic [11:0] OFF_MASK = 12'h234;
	localparam logic [11:0] OFF_ERR_STATE = 12'h240;
	localparam logic [11:0] OFF_ERR_CLEAR = 12'h400;
	// routing word layout
	localparam int LOW_W = 4;
	localparam int HIGH_W = 2;
	localparam int LINES_A = 8;
	// selector code fields
	localparam logic [1:0] KIND_TIMER = 2'h1;
	localparam logic [1:0] KIND_EDGE = 2'h2;
	localparam logic [1:0] KIND_GEN = 2'h3;
	localparam logic [1:0] GROUP_LAST_TIMER = 2'h1;
	localparam logic [1:0] GROUP_LAST_IO = 2'h2;
	localparam logic [5:0] CODE_PPS = 6'h20;
	// status, mask and control bit positions
	localparam int ST_PPS = 0;
	localparam int ST_CABLE_RX = 1;
	localparam int ST_CABLE_ERR = 2;
	localparam int ST_MASTER_TX = 3;
	localparam int ST_W = 4;
	localparam int CTL_MASTER = 0;
	// reset values
	localparam logic [5:0] SEL_RESET = 6'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] sec_low;
		logic [NS_W-1:0] ns;
	} cit_snap_type;

	typedef struct packed {
		logic valid;
		logic [31:0] seconds;
	} cit_time_msg_type;
endpackage

// File: logic/cit_route_sel.sv
// decoder of one cable line selector code onto its chosen local interrupt source
// assumes all sources are already on the block clock
`timescale 1ns/1ns
`default_nettype none
module cit_route_sel (
	input wire logic [5:0] code_i,
	input wire logic [7:0] timer_i,
	input wire logic [11:0] edge_i,
	input wire logic [11:0] soft_interrupt_generator_i,
	input wire logic pulse_per_second_i,
	output logic hit_o
);
	logic [1:0] group;
	logic [1:0] kind;
	logic [3:0] index;

	assign group = code_i[5:4];
	assign kind = code_i[3:2];
	assign index = {group, code_i[1:0]};

	// reserved codes give a quiet line
	always_comb begin
		hit_o = 1'b0;
		if (code_i == cit_pkg::CODE_PPS) begin
			hit_o = pulse_per_second_i;
		end else if (kind == cit_pkg::KIND_TIMER && group <= cit_pkg::GROUP_LAST_TIMER) begin
			hit_o = timer_i[index[2:0]];
		end else if (kind == cit_pkg::KIND_EDGE && group <= cit_pkg::GROUP_LAST_IO) begin
			hit_o = edge_i[index];
		end else if (kind == cit_pkg::KIND_GEN && group <= cit_pkg::GROUP_LAST_IO) begin
			hit_o = soft_interrupt_generator_i[index];
		end
	end
endmodule // cit_route_sel
`default_nettype wire

// File: logic/cit_top.sv
// cable interrupt routing, time snapshots, master time and cable error clearing
// assumes local sources, clock fields and cable messages on clk_i; gps pulse is a pin
// Function
// - twelve cable lines driven from chosen sources
// - six-bit selectors split over three words
// - selector codes decode to timers, edges, generators
// - pulse snapshot holds nanoseconds and two seconds
// - pulse snapshot refreshed on every gps pulse
// - cable snapshot holds nanoseconds and two seconds
// - cable snapshot refreshed on each master message
// - master time shows master card seconds
// - master sends seconds; receivers capture on arrival
// - write to clear location clears cable errors
// - clear ignores written data value
`timescale 1ns/1ns
`default_nettype none
module cit_top #(
	parameter int ERR_W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [cit_pkg::ADDR_W-1:0] addr_i,
	input wire logic [cit_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [cit_pkg::DATA_W-1:0] rdata_o,
	input wire logic [7:0] timer_irq_i,
	input wire logic [11:0] edge_irq_i,
	input wire logic [11:0] soft_interrupt_generator_i,
	input wire logic pulse_per_second_i,
	input wire logic [31:0] posix_seconds_i,
	input wire logic [cit_pkg::NS_W-1:0] posix_ns_i,
	input wire cit_pkg::cit_time_msg_type cable_rx_i,
	input wire logic [ERR_W-1:0] cable_error_i,
	output cit_pkg::cit_time_msg_type cable_tx_o,
	output logic [cit_pkg::LINES-1:0] cable_irq_o,
	output logic [ERR_W-1:0] cable_error_o,
	output logic irq_o
);
	if (ERR_W < 1 || ERR_W > cit_pkg::DATA_W) begin : g_check
		$error("cit_top: ERR_W out of range");
	end

	logic [cit_pkg::SEL_W-1:0] sel_reg [cit_pkg::LINES];
	logic [cit_pkg::LINES-1:0] hit;
	logic [cit_pkg::LINES-1:0] cable_irq_reg;
	logic pps_meta_reg;
	logic pps_sync_reg;
	logic pps_prev_reg;
	logic pps_edge;
	cit_pkg::cit_snap_type pps_snap_reg;
	cit_pkg::cit_snap_type cable_snap_reg;
	cit_pkg::cit_snap_type now_snap;
	logic [31:0] master_sec_reg;
	logic [31:0] prev_sec_reg;
	logic sec_prev_valid_reg;
	logic boundary;
	logic master_reg;
	cit_pkg::cit_time_msg_type cable_tx_reg;
	logic [ERR_W-1:0] err_reg;
	logic [ERR_W-1:0] err_next;
	logic [cit_pkg::ST_W-1:0] status_reg;
	logic [cit_pkg::ST_W-1:0] status_next;
	logic [cit_pkg::ST_W-1:0] events;
	logic [cit_pkg::ST_W-1:0] mask_reg;
	logic [cit_pkg::ST_W-1:0] mask_next;
	logic irq_reg;
	logic [cit_pkg::DATA_W-1:0] rdata_reg;
	logic [cit_pkg::DATA_W-1:0] rdata_next;
	logic [cit_pkg::DATA_W-1:0] route_a;
	logic [cit_pkg::DATA_W-1:0] route_b;
	logic [cit_pkg::DATA_W-1:0] route_hi;
	logic wr_a;
	logic wr_b;
	logic wr_hi;
	logic wr_clear;

	assign wr_a = wr_i && addr_i == cit_pkg::OFF_ROUTE_A;
	assign wr_b = wr_i && addr_i == cit_pkg::OFF_ROUTE_B;
	assign wr_hi = wr_i && addr_i == cit_pkg::OFF_ROUTE_HI;
	assign wr_clear = wr_i && addr_i == cit_pkg::OFF_ERR_CLEAR;

	// selector storage, decode and readback, one slice per line
	for (genvar i = 0; i < cit_pkg::LINES; i++) begin : g_line
		localparam int LO_POS = (i % cit_pkg::LINES_A) * cit_pkg::LOW_W;
		localparam int HI_POS = i * cit_pkg::HIGH_W;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sel_reg[i] <= cit_pkg::SEL_RESET;
			end else begin
				if ((i < cit_pkg::LINES_A) ? wr_a : wr_b) begin
					sel_reg[i][3:0] <= wdata_i[LO_POS +: cit_pkg::LOW_W];
				end
				if (wr_hi) begin
					sel_reg[i][5:4] <= wdata_i[HI_POS +: cit_pkg::HIGH_W];
				end
			end
		end
		cit_route_sel u_sel (
			.code_i(sel_reg[i]),
			.timer_i(timer_irq_i),
			.edge_i(edge_irq_i),
			.soft_interrupt_generator_i(soft_interrupt_generator_i),
			.pulse_per_second_i(pps_sync_reg),
			.hit_o(hit[i])
		);
		if (i < cit_pkg::LINES_A) begin : g_a
			assign route_a[LO_POS +: cit_pkg::LOW_W] = sel_reg[i][3:0];
		end else begin : g_b
			assign route_b[LO_POS +: cit_pkg::LOW_W] = sel_reg[i][3:0];
		end
		assign route_hi[HI_POS +: cit_pkg::HIGH_W] = sel_reg[i][5:4];
	end
	// unused upper bits of the short words read zero
	assign route_b[cit_pkg::DATA_W-1:(cit_pkg::LINES-cit_pkg::LINES_A)*cit_pkg::LOW_W] = '0;
	assign route_hi[cit_pkg::DATA_W-1:cit_pkg::LINES*cit_pkg::HIGH_W] = '0;

	// cable lines driven from chosen sources
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cable_irq_reg <= '0;
		end else begin
			cable_irq_reg <= hit;
		end
	end

	// gps pulse synchroniser and rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pps_meta_reg <= 1'b0;
			pps_sync_reg <= 1'b0;
			pps_prev_reg <= 1'b0;
		end else begin
			pps_meta_reg <= pulse_per_second_i;
			pps_sync_reg <= pps_meta_reg;
			pps_prev_reg <= pps_sync_reg;
		end
	end
	assign pps_edge = pps_sync_reg && !pps_prev_reg;
	assign now_snap = '{sec_low: posix_seconds_i[1:0], ns: posix_ns_i};

	// pulse snapshot
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pps_snap_reg <= '0;
		end else if (pps_edge) begin
			pps_snap_reg <= now_snap;
		end
	end

	// cable snapshot and master seconds on message arrival
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cable_snap_reg <= '0;
			master_sec_reg <= cit_pkg::WORD_RESET;
		end else if (cable_rx_i.valid) begin
			cable_snap_reg <= now_snap;
			master_sec_reg <= cable_rx_i.seconds;
		end else if (master_reg && boundary) begin
			master_sec_reg <= posix_seconds_i;
		end
	end

	// seconds boundary and master transmission
	assign boundary = sec_prev_valid_reg && posix_seconds_i != prev_sec_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_sec_reg <= cit_pkg::WORD_RESET;
			sec_prev_valid_reg <= 1'b0;
			cable_tx_reg <= '0;
		end else begin
			prev_sec_reg <= posix_seconds_i;
			sec_prev_valid_reg <= 1'b1;
			cable_tx_reg.valid <= master_reg && boundary;
			if (master_reg && boundary) begin
				cable_tx_reg.seconds <= posix_seconds_i;
			end
		end
	end

	// sticky cable errors, new errors win over a clear
	always_comb begin
		err_next = err_reg;
		if (wr_clear) begin
			err_next = '0;
		end
		err_next = err_next | cable_error_i;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_reg <= '0;
		end else begin
			err_reg <= err_next;
		end
	end

	// control and mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			master_reg <= 1'b0;
			mask_reg <= '0;
		end else begin
			if (wr_i && addr_i == cit_pkg::OFF_CONTROL) begin
				master_reg <= wdata_i[cit_pkg::CTL_MASTER];
			end
			mask_reg <= mask_next;
		end
	end

	// interrupt status, write one to clear, set wins
	always_comb begin
		events = '0;
		events[cit_pkg::ST_PPS] = pps_edge;
		events[cit_pkg::ST_CABLE_RX] = cable_rx_i.valid;
		events[cit_pkg::ST_CABLE_ERR] = |(cable_error_i & ~err_reg);
		events[cit_pkg::ST_MASTER_TX] = master_reg && boundary;
		status_next = status_reg;
		if (wr_i && addr_i == cit_pkg::OFF_STATUS) begin
			status_next = status_reg & ~wdata_i[cit_pkg::ST_W-1:0];
		end
		status_next = status_next | events;
		// new mask reaches irq at its write edge
		mask_next = mask_reg;
		if (wr_i && addr_i == cit_pkg::OFF_MASK) begin
			mask_next = wdata_i[cit_pkg::ST_W-1:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg <= |(status_next & mask_next);
		end
	end

	// read port, data valid only in the cycle after the strobe
	always_comb begin
		rdata_next = '0;
		if (rd_i) begin
			unique case (addr_i)
				cit_pkg::OFF_ROUTE_A: rdata_next = route_a;
				cit_pkg::OFF_ROUTE_B: rdata_next = route_b;
				cit_pkg::OFF_ROUTE_HI: rdata_next = route_hi;
				cit_pkg::OFF_PPS_SNAP: rdata_next = pps_snap_reg;
				cit_pkg::OFF_CABLE_SNAP: rdata_next = cable_snap_reg;
				cit_pkg::OFF_MASTER_SEC: rdata_next = master_sec_reg;
				cit_pkg::OFF_CONTROL: rdata_next[cit_pkg::CTL_MASTER] = master_reg;
				cit_pkg::OFF_STATUS: rdata_next[cit_pkg::ST_W-1:0] = status_reg;
				cit_pkg::OFF_MASK: rdata_next[cit_pkg::ST_W-1:0] = mask_reg;
				cit_pkg::OFF_ERR_STATE: rdata_next[ERR_W-1:0] = err_reg;
				default: rdata_next = '0;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign cable_irq_o = cable_irq_reg;
	assign cable_tx_o = cable_tx_reg;
	assign cable_error_o = err_reg;
	assign irq_o = irq_reg;

	// checks
	property p_reserved_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(sel_reg[0] == cit_pkg::SEL_RESET) [*2] |-> !cable_irq_o[0];
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code drove line");

	property p_route_follow;
		@(posedge clk_i) disable iff (rst_i)
		(sel_reg[1] == 6'h04) |=> cable_irq_o[1] == $past(timer_irq_i[0]);
	endproperty
	a_route_follow: assert property (p_route_follow) else $error("line 1 not following timer 0");

	property p_pps_capture;
		@(posedge clk_i) disable iff (rst_i)
		pps_edge |=> pps_snap_reg == {$past(posix_seconds_i[1:0]), $past(posix_ns_i)};
	endproperty
	a_pps_capture: assert property (p_pps_capture) else $error("pulse snapshot wrong");

	property p_pps_hold;
		@(posedge clk_i) disable iff (rst_i)
		!pps_edge |=> $stable(pps_snap_reg);
	endproperty
	a_pps_hold: assert property (p_pps_hold) else $error("pulse snapshot changed");

	property p_cable_capture;
		@(posedge clk_i) disable iff (rst_i)
		cable_rx_i.valid |=> cable_snap_reg.ns == $past(posix_ns_i)
			&& master_sec_reg == $past(cable_rx_i.seconds);
	endproperty
	a_cable_capture: assert property (p_cable_capture) else $error("cable capture wrong");

	property p_master_send;
		@(posedge clk_i) disable iff (rst_i)
		master_reg && sec_prev_valid_reg && posix_seconds_i != prev_sec_reg
			|=> cable_tx_o.valid && cable_tx_o.seconds == $past(posix_seconds_i);
	endproperty
	a_master_send: assert property (p_master_send) else $error("master seconds not sent");

	property p_err_clear;
		@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == cit_pkg::OFF_ERR_CLEAR |=> cable_error_o == $past(cable_error_i);
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("cable errors not cleared");

	property p_read_idle;
		@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == '0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

	property p_route_hi_zero;
		@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == cit_pkg::OFF_ROUTE_HI |=> rdata_o[31:24] == 8'h00;
	endproperty
	a_route_hi_zero: assert property (p_route_hi_zero) else $error("reserved bits not zero");

	property p_sel_write;
		@(posedge clk_i) disable iff (rst_i)
		wr_i && addr_i == cit_pkg::OFF_ROUTE_B ##1 rd_i && addr_i == cit_pkg::OFF_ROUTE_B
			|=> rdata_o[15:0] == $past(wdata_i[15:0], 2);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("selector readback wrong");

	property p_snap_layout;
		@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == cit_pkg::OFF_CABLE_SNAP |=> rdata_o == $past(cable_snap_reg);
	endproperty
	a_snap_layout: assert property (p_snap_layout) else $error("cable snapshot read wrong");

	property p_pps_fields;
		@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i == cit_pkg::OFF_PPS_SNAP |=> rdata_o[31:30] == $past(pps_snap_reg.sec_low);
	endproperty
	a_pps_fields: assert property (p_pps_fields) else $error("pulse snapshot seconds misplaced");
endmodule // cit_top
`default_nettype wire

// File: bench/cit_peer_model.sv
// peer card on the far side of the cable: sends master time messages, logs sent seconds
// assumes the same clock as the block
`timescale 1ns/1ns
`default_nettype none
module cit_peer_model (
	input wire logic clk_i,
	input wire cit_pkg::cit_time_msg_type tx_i,
	output var cit_pkg::cit_time_msg_type rx_o
);
	int req_cnt = 0;
	int done_cnt = 0;
	int tx_cnt = 0;
	logic [31:0] req_sec = 32'h0000_0000;
	logic [31:0] tx_sec = 32'h0000_0000;
	initial rx_o = '0;
	// one message per request, idle seconds toggle
	always @(posedge clk_i) begin
		if (req_cnt != done_cnt) begin
			rx_o <= {1'b1, req_sec};
			done_cnt <= done_cnt + 1;
		end else begin
			rx_o <= {1'b0, ~rx_o.seconds};
		end
		if (tx_i.valid === 1'b1) begin
			tx_cnt <= tx_cnt + 1;
			tx_sec <= tx_i.seconds;
		end
	end
	task automatic send(input logic [31:0] sec);
		req_sec = sec;
		req_cnt++;
	endtask
endmodule // cit_peer_model
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the cable routing and time snapshot block
// assumes cit_pkg, cit_top and the peer model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [7:0] timer_irq_i = 8'h00;
	logic [11:0] edge_irq_i = 12'h000;
	logic [11:0] soft_interrupt_generator_i = 12'h000;
	logic pulse_per_second_i = 1'b0;
	logic [31:0] posix_seconds_i = 32'h0000_0000;
	logic [29:0] posix_ns_i = 30'h0000_0000;
	logic [3:0] cable_error_i = 4'h0;
	cit_pkg::cit_time_msg_type cable_rx_i;
	cit_pkg::cit_time_msg_type cable_tx_o;
	logic [11:0] cable_irq_o;
	logic [3:0] cable_error_o;
	logic irq_o;
	int fails = 0;
	int total_checks = 0;
	logic [31:0] lfsr = 32'h4040_0335;
	logic [5:0] sel_m [12];
	logic [31:0] d;

	always #25 clk_i = ~clk_i;

	cit_top u_cit_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_irq_i(timer_irq_i),
		.edge_irq_i(edge_irq_i), .soft_interrupt_generator_i(soft_interrupt_generator_i),
		.pulse_per_second_i(pulse_per_second_i), .posix_seconds_i(posix_seconds_i),
		.posix_ns_i(posix_ns_i), .cable_rx_i(cable_rx_i), .cable_error_i(cable_error_i),
		.cable_tx_o(cable_tx_o), .cable_irq_o(cable_irq_o), .cable_error_o(cable_error_o),
		.irq_o(irq_o));
	cit_peer_model u_peer (.clk_i(clk_i), .tx_i(cable_tx_o), .rx_o(cable_rx_i));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// source chosen by a selector code
	function automatic logic pick(input logic [5:0] c);
		int lo;
		int grp;
		int kind;
		lo = c % 4;
		grp = c / 16;
		kind = (c / 4) % 4;
		if (c == 6'h20) return pulse_per_second_i;
		if (kind == 1 && grp < 2) return timer_irq_i[grp * 4 + lo];
		if (kind == 2 && grp < 3) return edge_irq_i[grp * 4 + lo];
		if (kind == 3 && grp < 3) return soft_interrupt_generator_i[grp * 4 + lo];
		return 1'b0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// write then read on back-to-back strobes
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic see(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic check_lines();
		logic [11:0] x;
		logic [31:0] r;
		@(posedge clk_i);
		r = rnd();
		timer_irq_i <= r[7:0];
		edge_irq_i <= r[19:8];
		soft_interrupt_generator_i <= r[31:20];
		r = rnd();
		pulse_per_second_i <= r[0];
		see(6);
		for (int i = 0; i < 12; i++) x[i] = pick(sel_m[i]);
		chk({20'h0, cable_irq_o}, {20'h0, x});
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk_i);
		fails++;
		final_report();
	end

	initial begin
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] h;
		logic [31:0] s;
		logic [31:0] n;
		int t0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(cit_pkg::OFF_ROUTE_A);
		chk(d, 32'h0000_0000);
		rd(cit_pkg::OFF_ROUTE_HI);
		chk(d, 32'h0000_0000);
		chk({19'h0, irq_o, cable_irq_o}, 32'h0000_0000);
		$display("test reset done");
		repeat (4) begin
			a = rnd();
			b = rnd();
			h = rnd();
			wr(cit_pkg::OFF_ROUTE_A, a);
			wr(cit_pkg::OFF_ROUTE_HI, h);
			wr_rd(cit_pkg::OFF_ROUTE_B, b);
			chk(d, {16'h0000, b[15:0]});
			rd(cit_pkg::OFF_ROUTE_A);
			chk(d, a);
			rd(cit_pkg::OFF_ROUTE_HI);
			chk(d, {8'h00, h[23:0]});
			for (int i = 0; i < 12; i++) begin
				sel_m[i] = {h[2*i+1 -: 2], (i < 8) ? a[4*i +: 4] : b[4*(i-8) +: 4]};
			end
			check_lines();
		end
		$display("test routing layout done");
		for (int c = 0; c < 64; c++) begin
			a = c;
			b = rnd();
			wr(cit_pkg::OFF_ROUTE_A, {8{a[3:0]}});
			wr(cit_pkg::OFF_ROUTE_B, {b[31:16], {4{a[3:0]}}});
			wr(cit_pkg::OFF_ROUTE_HI, {8'h00, {12{a[5:4]}}});
			for (int i = 0; i < 12; i++) sel_m[i] = a[5:0];
			check_lines();
			check_lines();
		end
		$display("test selector codes done");
		wr(cit_pkg::OFF_MASK, 32'h0000_0000);
		repeat (2) begin
			@(posedge clk_i);
			pulse_per_second_i <= 1'b0;
			s = rnd();
			n = rnd();
			posix_seconds_i <= s;
			posix_ns_i <= n[29:0];
			see(5);
			wr(cit_pkg::OFF_STATUS, 32'h0000_000F);
			@(posedge clk_i);
			pulse_per_second_i <= 1'b1;
			see(6);
			chk({31'h0, irq_o}, 32'h0000_0000);
			wr(cit_pkg::OFF_PPS_SNAP, rnd());
			rd(cit_pkg::OFF_PPS_SNAP);
			chk(d, {s[1:0], n[29:0]});
			rd(cit_pkg::OFF_PPS_SNAP);
			chk(d, {s[1:0], n[29:0]});
		end
		wr(cit_pkg::OFF_MASK, 32'h0000_0001);
		see(1);
		chk({31'h0, irq_o}, 32'h0000_0001);
		wr(cit_pkg::OFF_STATUS, 32'h0000_0001);
		see(1);
		chk({31'h0, irq_o}, 32'h0000_0000);
		rd(12'h100);
		chk(d, 32'h0000_0000);
		$display("test pulse snapshot done");
		repeat (2) begin
			@(posedge clk_i);
			n = rnd();
			posix_ns_i <= n[29:0];
			posix_seconds_i <= n ^ 32'h5A5A_0F0F;
			s = rnd();
			#1;
			u_peer.send(s);
			see(4);
			rd(cit_pkg::OFF_CABLE_SNAP);
			chk(d, {n[1:0] ^ 2'h3, n[29:0]});
			rd(cit_pkg::OFF_MASTER_SEC);
			chk(d, s);
		end
		$display("test cable message done");
		wr(cit_pkg::OFF_CONTROL, 32'h0000_0001);
		t0 = u_peer.tx_cnt;
		@(posedge clk_i);
		s = posix_seconds_i + 32'h0000_0001;
		posix_seconds_i <= s;
		see(3);
		chk(32'(u_peer.tx_cnt - t0), 32'h0000_0001);
		chk(u_peer.tx_sec, s);
		rd(cit_pkg::OFF_MASTER_SEC);
		chk(d, s);
		wr(cit_pkg::OFF_CONTROL, 32'h0000_0000);
		$display("test master send done");
		for (int j = 0; j < 3; j++) begin
			@(posedge clk_i);
			cable_error_i <= 4'h9;
			@(posedge clk_i);
			cable_error_i <= 4'h0;
			see(2);
			chk({28'h0, cable_error_o}, 32'h0000_0009);
			wr(cit_pkg::OFF_ERR_CLEAR, (j == 0) ? 32'h0 : (j == 1) ? 32'hFFFF_FFFF : rnd());
			see(1);
			chk({28'h0, cable_error_o}, 32'h0000_0000);
		end
		$display("test error clear done");
		final_report();
	end
endmodule // testbench
`default_nettype wire
